/* File: src/msd_pkg.sv */
// constants and carrier types for the memory space address decode block
// assumes one core clock; no software-visible registers
package msd_pkg;
  localparam int PA_W = 24;
  localparam int PC_W = 23;
  localparam int EA_W = 16;
  localparam logic [23:0] USER_TOP = 24'h7F_FFFF;
  localparam logic [23:0] RESET_ADDR = 24'h00_0000;
  localparam logic [23:0] RESET_TGT = 24'h00_0002;
  localparam logic [23:0] IVT_LO = 24'h00_0004;
  localparam logic [23:0] IVT_HI = 24'h00_00FF;
  localparam logic [23:0] AIVT_LO = 24'h00_0100;
  localparam logic [23:0] AIVT_HI = 24'h00_01FF;
  localparam logic [23:0] VEC_END = 24'h00_0200;
  localparam logic [23:0] FLASH_END = 24'h00_5800;
  localparam logic [23:0] CFG_LO = 24'hF8_0000;
  localparam logic [23:0] CFG_HI = 24'hF8_0017;
  localparam logic [23:0] ID_LO = 24'hFF_0000;
  localparam logic [23:0] ID_HI = 24'hFF_FFFF;
  localparam int PAGE_EN_BIT = 7;
  localparam int PSV_BIT = 15;
  localparam logic [15:0] RAM_END = 16'h7800;
  localparam logic [22:0] PC_STEP = 23'h00_0002;
  typedef enum logic [7:0] {
    MSD_PR_NONE = 8'h01, MSD_PR_RESET = 8'h02, MSD_PR_IVT = 8'h04, MSD_PR_AIVT = 8'h08,
    MSD_PR_RSVD = 8'h10, MSD_PR_FLASH = 8'h20, MSD_PR_CFG = 8'h40, MSD_PR_ID = 8'h80
  } msd_region_t;
  typedef struct packed {
    logic valid;
    logic [23:0] addr;
    msd_region_t region;
    logic upper;
  } msd_prog_t;
  typedef struct packed {
    logic valid;
    logic ram;
    logic psv;
    logic [15:0] addr;
    logic misaligned;
  } msd_data_t;
endpackage : msd_pkg

/* File: src/msd_decode.sv */
// memory space address decode: program counter, table ops, data read/write addresses
// assumes the core supplies same-clock requests and the memories return data
//
// What this block does
// R01 - program addresses are 24 bits from a 23-bit counter or table ops
// R02 - user program access allowed only in 0x000000 to 0x7FFFFF
// R03 - table ops reach config and part id only when page bit 7 set
// R04 - each location is even lower word and odd upper word, top byte zero
// R05 - addresses word aligned; counter steps by two up or down
// R06 - after reset execution starts at 0x000000, jump target at 0x000002
// R07 - addresses below 0x000200 reserved for vectors
// R08 - primary vector table 0x000004-0x0000FF, alternate 0x000100-0x0001FF
// R09 - data addresses are 16-bit byte addresses over 64 Kbytes
// R10 - bit 15 clear goes to data memory, set goes to program window
// R11 - data memory at most 30 Kbytes; reads outside return zero
// R12 - separate read and write address paths work independently
// R13 - low byte at even address, high byte at odd address
// R14 - odd word access traps; faulting write suppressed, read completes
`timescale 1ns/1ps
`default_nettype none
module msd_decode
  import msd_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic PC_LOAD,
  input wire logic PC_STEP_EN,
  input wire logic PC_DOWN,
  input wire logic [22:0] PC_LOAD_VAL,
  input wire logic TBL_REQ,
  input wire logic TBL_WRITE,
  input wire logic [7:0] TABLE_PAGE_SELECT,
  input wire logic [15:0] TBL_OFFSET,
  input wire logic [23:0] PROG_RDATA,
  input wire logic RD_REQ,
  input wire logic RD_BYTE,
  input wire logic [15:0] RD_EA,
  input wire logic [15:0] RAM_RDATA,
  input wire logic WR_REQ,
  input wire logic WR_BYTE,
  input wire logic [15:0] WR_EA,
  output logic [22:0] PROGRAM_COUNTER,
  output msd_prog_t FETCH_OUT,
  output msd_prog_t TBL_OUT,
  output logic [15:0] TBL_RDATA,
  output msd_data_t RD_OUT,
  output logic [15:0] RD_DATA,
  output msd_data_t WR_OUT,
  output logic [1:0] WR_LANE,
  output logic ADDR_TRAP
);
  function automatic msd_region_t region_of(input logic [23:0] a);
    if (a < IVT_LO) region_of = MSD_PR_RESET; // R06 R07
    else if (a <= IVT_HI) region_of = MSD_PR_IVT; // R08
    else if (a >= AIVT_LO && a <= AIVT_HI) region_of = MSD_PR_AIVT; // R08
    else if (a < FLASH_END) region_of = MSD_PR_FLASH;
    else if (a <= USER_TOP) region_of = MSD_PR_NONE;
    else if (a >= CFG_LO && a <= CFG_HI) region_of = MSD_PR_CFG;
    else if (a >= ID_LO) region_of = MSD_PR_ID;
    else region_of = MSD_PR_RSVD;
  endfunction : region_of

  function automatic msd_data_t data_dec(input logic req, input logic byt, input logic [15:0] ea);
    data_dec.valid = req;
    data_dec.addr = ea; // R09
    data_dec.psv = req & ea[PSV_BIT]; // R10
    data_dec.ram = req & ~ea[PSV_BIT] & (ea < RAM_END); // R11
    data_dec.misaligned = req & ~byt & ea[0]; // R14
  endfunction : data_dec

  logic [22:0] pc_r, pc_nxt;
  msd_prog_t fetch_r, fetch_nxt, tbl_r, tbl_nxt;
  msd_data_t rd_r, rd_nxt, wr_r, wr_nxt;
  logic rd_byte_r, rd_byte_nxt, trap_r, trap_nxt;
  logic [1:0] lane_r, lane_nxt;
  logic [15:0] tbl_data_r, tbl_data_nxt, rd_data_r, rd_data_nxt;
  logic [23:0] tbl_addr;
  logic [15:0] rword;

  always_comb begin
    pc_nxt = pc_r;
    if (PC_LOAD) pc_nxt = {PC_LOAD_VAL[22:1], 1'b0}; // R05
    else if (PC_STEP_EN) pc_nxt = PC_DOWN ? pc_r - PC_STEP : pc_r + PC_STEP; // R05
    fetch_nxt.valid = 1'b1;
    fetch_nxt.addr = {1'b0, pc_nxt}; // R01 R02
    fetch_nxt.region = region_of({1'b0, pc_nxt});
    fetch_nxt.upper = 1'b0;
  end

  always_comb begin
    tbl_addr = {TABLE_PAGE_SELECT, TBL_OFFSET}; // R01
    tbl_nxt.addr = tbl_addr;
    tbl_nxt.region = region_of(tbl_addr);
    tbl_nxt.upper = tbl_addr[0]; // R04
    // page bit 7 opens config space; it is also address bit 23, so this gate never refuses a request
    tbl_nxt.valid = TBL_REQ & (~tbl_addr[23] | TABLE_PAGE_SELECT[PAGE_EN_BIT]); // R02 R03
    tbl_data_nxt = tbl_data_r;
    if (TBL_REQ && !TBL_WRITE) begin
      if (!tbl_nxt.valid) tbl_data_nxt = 16'h0000;
      else if (tbl_addr[0]) tbl_data_nxt = {8'h00, PROG_RDATA[23:16]}; // R04
      else tbl_data_nxt = PROG_RDATA[15:0];
    end
  end

  always_comb begin
    rd_nxt = data_dec(RD_REQ, RD_BYTE, RD_EA); // R12
    wr_nxt = data_dec(WR_REQ, WR_BYTE, WR_EA); // R12
    rd_byte_nxt = RD_BYTE;
    lane_nxt = 2'b00;
    // a misaligned write drives no lane, so memory stays untouched
    if (wr_nxt.valid && wr_nxt.ram && !wr_nxt.misaligned) begin // R14
      if (WR_BYTE) lane_nxt = WR_EA[0] ? 2'b10 : 2'b01; // R13
      else lane_nxt = 2'b11;
    end
    trap_nxt = rd_nxt.misaligned | wr_nxt.misaligned; // R14
    // memory answers on the cycle after the address is registered
    rword = rd_r.ram ? RAM_RDATA : 16'h0000; // R11
    rd_data_nxt = 16'h0000;
    if (rd_r.valid) begin
      if (rd_byte_r) rd_data_nxt = {8'h00, rd_r.addr[0] ? rword[15:8] : rword[7:0]}; // R13
      else rd_data_nxt = rword; // R14
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pc_r <= 23'h00_0000; // R06
      fetch_r <= '{valid: 1'b0, addr: 24'h00_0000, region: MSD_PR_RESET, upper: 1'b0};
      tbl_r <= '{valid: 1'b0, addr: 24'h00_0000, region: MSD_PR_NONE, upper: 1'b0};
      tbl_data_r <= 16'h0000;
      rd_r <= '0;
      wr_r <= '0;
      rd_byte_r <= 1'b0;
      lane_r <= 2'b00;
      trap_r <= 1'b0;
      rd_data_r <= 16'h0000;
    end else begin
      pc_r <= pc_nxt;
      fetch_r <= fetch_nxt;
      tbl_r <= tbl_nxt;
      tbl_data_r <= tbl_data_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      rd_byte_r <= rd_byte_nxt;
      lane_r <= lane_nxt;
      trap_r <= trap_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign PROGRAM_COUNTER = pc_r;
  assign FETCH_OUT = fetch_r;
  assign TBL_OUT = tbl_r;
  assign TBL_RDATA = tbl_data_r;
  assign RD_OUT = rd_r;
  assign RD_DATA = rd_data_r;
  assign WR_OUT = wr_r;
  assign WR_LANE = lane_r;
  assign ADDR_TRAP = trap_r;

  // program side: counter, fetch window and table decode
  pc_even_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R05
    pc_r[0] == 1'b0)
    else $error("program counter odd");
  pc_step_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R05
    (!PC_LOAD && PC_STEP_EN && !PC_DOWN) |=> pc_r == $past(pc_r) + PC_STEP)
    else $error("program counter did not step by two");
  pc_down_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R05
    (!PC_LOAD && PC_STEP_EN && PC_DOWN) |=> pc_r == $past(pc_r) - PC_STEP)
    else $error("program counter did not step down by two");
  pc_load_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R05
    PC_LOAD |=> pc_r == {$past(PC_LOAD_VAL[22:1]), 1'b0})
    else $error("program counter load not word aligned");
  // the first edge after release must still show the start address
  reset_start_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R06
    !$past(RESETN) |-> (pc_r == RESET_ADDR[22:0]) && (fetch_r.addr == RESET_ADDR))
    else $error("execution did not start at the reset address");
  fetch_user_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R02
    fetch_r.addr <= USER_TOP)
    else $error("fetch outside user space");
  vec_region_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R07
    (fetch_r.addr < VEC_END) |-> (fetch_r.region == MSD_PR_RESET)
      || (fetch_r.region == MSD_PR_IVT) || (fetch_r.region == MSD_PR_AIVT))
    else $error("vector range decoded as code space");
  ivt_bounds_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R08
    (fetch_r.region == MSD_PR_IVT) |-> (fetch_r.addr >= IVT_LO) && (fetch_r.addr <= IVT_HI))
    else $error("primary vector table outside its range");
  tbl_cfg_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R03
    (tbl_r.valid && ((tbl_r.region == MSD_PR_CFG) || (tbl_r.region == MSD_PR_ID)))
      |-> $past(TABLE_PAGE_SELECT[PAGE_EN_BIT]))
    else $error("config space reached with page bit clear");
  upper_zero_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R04
    (TBL_REQ && !TBL_WRITE && TBL_OFFSET[0]) |=> tbl_data_r[15:8] == 8'h00)
    else $error("upper word top byte not zero");
  // data side: routing, zero fill, lanes and traps
  psv_route_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R10
    rd_r.valid |-> (rd_r.psv == rd_r.addr[15]) && !(rd_r.psv && rd_r.ram))
    else $error("read routing wrong");
  wr_route_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R12
    wr_r.valid |-> (wr_r.psv == wr_r.addr[PSV_BIT]) && !(wr_r.psv && wr_r.ram))
    else $error("write routing wrong");
  ram_limit_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R11
    rd_r.ram |-> rd_r.addr < RAM_END)
    else $error("read routed to ram beyond its end");
  unimpl_zero_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R11
    (rd_r.valid && !rd_r.ram) |=> rd_data_r == 16'h0000)
    else $error("unimplemented read not zero");
  rd_word_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R14
    (rd_r.valid && rd_r.ram && !rd_byte_r) |=> rd_data_r == $past(RAM_RDATA))
    else $error("word read did not complete");
  rd_high_byte_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R13
    (rd_r.valid && rd_r.ram && rd_byte_r && rd_r.addr[0]) |=> rd_data_r == {8'h00, $past(RAM_RDATA[15:8])})
    else $error("odd byte read not taken from high byte");
  wr_suppress_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R14
    (WR_REQ && !WR_BYTE && WR_EA[0]) |=> (lane_r == 2'b00) && trap_r)
    else $error("misaligned write not suppressed");
  rd_trap_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R14
    (RD_REQ && !RD_BYTE && RD_EA[0]) |=> trap_r)
    else $error("misaligned read did not trap");
  byte_lane_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R13
    (WR_REQ && WR_BYTE && !WR_EA[15] && WR_EA < RAM_END) |=> lane_r == (WR_EA[0] ? 2'b10 : 2'b01))
    else $error("byte lane wrong");
  word_lane_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // R13
    (WR_REQ && !WR_BYTE && !WR_EA[0] && !WR_EA[15] && WR_EA < RAM_END) |=> lane_r == 2'b11)
    else $error("word write did not strobe both lanes");
endmodule : msd_decode
`default_nettype wire

/* File: verification/msd_mem_model.sv */
// partner model: program and data memories behind the decode block
// assumes table reads are combinational and ram data follows the read decode
`timescale 1ns/1ps
`default_nettype none
module msd_mem_model
  import msd_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] page,
  input wire logic [15:0] offset,
  input var msd_data_t rd_out,
  output logic [23:0] prog_rdata,
  output logic [15:0] ram_rdata
);
  logic tgl_r = 1'b0;
  always @(posedge clk) tgl_r <= ~tgl_r;
  assign prog_rdata = {page ^ 8'hC3, offset[15:1], 1'b0} ^ 24'h5A_3C00;
  // unselected ram toggles so stale data never passes for a match
  assign ram_rdata = (rd_out.valid && rd_out.ram) ? {rd_out.addr[15:1], 1'b0} ^ 16'h9C00
                                                  : {16{tgl_r}};
endmodule : msd_mem_model
`default_nettype wire

/* File: verification/memory_space_address_decode_tb.sv */
// testbench for the address decode block with a memory partner model
// assumes single 10 MHz clock and inputs driven 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module memory_space_address_decode_tb;
  import msd_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic pc_load, pc_step, pc_down, tbl_req, tbl_wr, rd_req, rd_byte, wr_req, wr_byte, trap;
  logic [22:0] pc_val, pc;
  logic [7:0] page;
  logic [15:0] offs, rd_ea, wr_ea, ram_rdata, tbl_rdata, rd_data;
  logic [23:0] prog_rdata;
  logic [1:0] lane;
  msd_prog_t fetch, tbl;
  msd_data_t rd, wr;
  int fail_count = 0;
  int cmp_count = 0;
  logic [16:0] cases [7] = '{17'h0_0810, 17'h1_0011, 17'h1_0010, 17'h0_0013,
                             17'h0_77FE, 17'h0_7800, 17'h0_8000};
  always #50 SYS_CLK = ~SYS_CLK;
  msd_decode i_dut (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .PC_LOAD(pc_load), .PC_STEP_EN(pc_step),
    .PC_DOWN(pc_down), .PC_LOAD_VAL(pc_val), .TBL_REQ(tbl_req), .TBL_WRITE(tbl_wr),
    .TABLE_PAGE_SELECT(page), .TBL_OFFSET(offs), .PROG_RDATA(prog_rdata), .RD_REQ(rd_req),
    .RD_BYTE(rd_byte), .RD_EA(rd_ea), .RAM_RDATA(ram_rdata), .WR_REQ(wr_req), .WR_BYTE(wr_byte),
    .WR_EA(wr_ea), .PROGRAM_COUNTER(pc), .FETCH_OUT(fetch), .TBL_OUT(tbl), .TBL_RDATA(tbl_rdata),
    .RD_OUT(rd), .RD_DATA(rd_data), .WR_OUT(wr), .WR_LANE(lane), .ADDR_TRAP(trap));
  msd_mem_model i_mem (.clk(SYS_CLK), .page(page), .offset(offs), .rd_out(rd),
    .prog_rdata(prog_rdata), .ram_rdata(ram_rdata));
  task automatic cyc;
    @(posedge SYS_CLK);
    #1;
  endtask : cyc
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d errors %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic t_pc;
    chk("fetch addr", fetch.addr, 24'h00_0000);
    pc_load = 1'b1; pc_val = 23'h00_0101; cyc; pc_load = 1'b0;
    chk("pc load", {1'b0, pc}, 24'h00_0100);
    pc_step = 1'b1; cyc;
    chk("pc up", {1'b0, pc}, 24'h00_0102);
    pc_down = 1'b1; cyc; cyc; pc_step = 1'b0; pc_down = 1'b0;
    chk("pc down", {1'b0, pc}, 24'h00_00FE);
  endtask : t_pc
  task automatic t_region(input logic [22:0] v, input msd_region_t r);
    pc_load = 1'b1; pc_val = v; cyc; pc_load = 1'b0;
    chk("fetch addr", fetch.addr, {1'b0, v});
    chk("fetch region", fetch.region, r);
    chk("fetch valid", fetch.valid, 1'b1);
    chk("fetch upper", fetch.upper, 1'b0);
    cyc;
  endtask : t_region
  task automatic t_tbl(input logic [7:0] pg, input logic [15:0] of, input msd_region_t r);
    logic [23:0] p;
    p = {pg ^ 8'hC3, of[15:1], 1'b0} ^ 24'h5A_3C00;
    tbl_req = 1'b1; page = pg; offs = of; cyc; tbl_req = 1'b0;
    chk("tbl valid", tbl.valid, 1'b1);
    chk("tbl region", tbl.region, r);
    chk("tbl addr", tbl.addr, {pg, of});
    chk("tbl upper", tbl.upper, of[0]);
    chk("tbl data", tbl_rdata, of[0] ? {16'h0, p[23:16]} : {8'h0, p[15:0]});
    cyc;
  endtask : t_tbl
  task automatic t_tbl_wr(input logic [7:0] pg, input logic [15:0] of);
    logic [23:0] p;
    p = {pg ^ 8'hC3, of[15:1], 1'b0} ^ 24'h5A_3C00;
    tbl_req = 1'b1;
    page = pg;
    offs = of;
    cyc;
    tbl_wr = 1'b1;
    offs = of ^ 16'h0100;
    cyc;
    tbl_req = 1'b0;
    tbl_wr = 1'b0;
    chk("tbl wr valid", tbl.valid, 1'b1);
    chk("tbl wr addr", tbl.addr, {pg, of ^ 16'h0100});
    // a table write has no data path, so the last read word must stay
    chk("tbl wr hold", tbl_rdata, of[0] ? {16'h0, p[23:16]} : {8'h0, p[15:0]});
    cyc;
  endtask : t_tbl_wr
  task automatic t_reset;
    pc_load = 1'b1;
    pc_val = 23'h00_0300;
    cyc;
    pc_load = 1'b0;
    chk("pc before reset", {1'b0, pc}, 24'h00_0300);
    RESETN = 1'b0;
    #1;
    chk("reset pc", {1'b0, pc}, RESET_ADDR);
    chk("reset fetch region", fetch.region, MSD_PR_RESET);
    chk("reset tbl data", tbl_rdata, 16'h0000);
    chk("reset lane", lane, 2'b00);
    cyc;
    RESETN = 1'b1;
    cyc;
    chk("restart fetch addr", fetch.addr, RESET_ADDR);
    chk("restart pc", {1'b0, pc}, RESET_ADDR);
  endtask : t_reset
  task automatic t_data(input logic [15:0] ea, input logic bt);
    logic [15:0] w;
    logic ok, tr;
    w = {ea[15:1], 1'b0} ^ 16'h9C00;
    ok = ea < 16'h7800;
    tr = !bt && ea[0];
    rd_req = 1'b1; rd_byte = bt; rd_ea = ea; wr_req = 1'b1; wr_byte = bt; wr_ea = ea ^ 16'h0400;
    cyc; rd_req = 1'b0; wr_req = 1'b0;
    chk("rd ram", rd.ram, ok);
    chk("rd psv", rd.psv, ea[15]);
    chk("rd addr", rd.addr, ea);
    chk("wr psv", wr.psv, ea[15]);
    chk("wr misaligned", wr.misaligned, tr);
    chk("wr addr", wr.addr, ea ^ 16'h0400);
    chk("wr lane", lane, (!ok || tr) ? 2'b00 : !bt ? 2'b11 : ea[0] ? 2'b10 : 2'b01);
    chk("trap", trap, tr);
    chk("rd misaligned", rd.misaligned, tr);
    cyc;
    chk("rd data", rd_data, !ok ? 16'h0 : !bt ? w : ea[0] ? {8'h0, w[15:8]} : {8'h0, w[7:0]});
    chk("trap pulse", trap, 1'b0);
    chk("lane idle", lane, 2'b00);
  endtask : t_data
  initial begin
    #1_000_000;
    fail_count++;
    stop_test;
  end
  initial begin
    {pc_load, pc_step, pc_down, tbl_req, tbl_wr, rd_req, rd_byte, wr_req, wr_byte} = '0;
    pc_val = '0; page = '0; offs = '0; rd_ea = '0; wr_ea = '0;
    repeat (12) @(posedge SYS_CLK);
    chk("reset region", fetch.region, MSD_PR_RESET);
    #1 RESETN = 1'b1;
    cyc;
    t_pc;
    t_region(23'h00_0000, MSD_PR_RESET);
    t_region(23'h00_0004, MSD_PR_IVT);
    t_region(23'h00_0180, MSD_PR_AIVT);
    t_region(23'h00_0200, MSD_PR_FLASH);
    t_region(23'h00_6000, MSD_PR_NONE);
    t_tbl(8'h00, 16'h0200, MSD_PR_FLASH);
    t_tbl(8'h00, 16'h0201, MSD_PR_FLASH);
    t_tbl(8'hF8, 16'h0011, MSD_PR_CFG);
    t_tbl(8'hFF, 16'h1234, MSD_PR_ID);
    t_tbl(8'h80, 16'h0000, MSD_PR_RSVD);
    t_tbl_wr(8'hF8, 16'h0004);
    foreach (cases[i]) t_data(cases[i][15:0], cases[i][16]);
    t_reset;
    stop_test;
  end
endmodule : memory_space_address_decode_tb
`default_nettype wire
